/* File: common/spe_pkg.sv */
// Constants, types and helpers for the serial unit poll engine
// Operation
// (RULE_01) Command register change starts that unit's transaction
// (RULE_02) Request frame: 02, unit, cmd, 03, sum, 0D
// (RULE_03) Wait at most 50 ms for either reply
// (RULE_04) Discard nonmatching characters, keep waiting
// (RULE_05) Timeout or bad check byte: count, resend
// (RULE_06) Acknowledge: unit, cmd char, 06, check, 0D
// (RULE_07) Check byte: 8-bit sum of characters one-three
// (RULE_08) Error reply adds code digit, 15, four-char check
// (RULE_09) Timeout setting counts 10 ms units
// (RULE_10) Acknowledge posts status 1 or 256
// (RULE_11) Error reply posts status 2 or 512
// (RULE_12) Three failed attempts post status 4 or 1024
// (RULE_13) At most three requests per transaction
// (RULE_14) After status, wait for same unit's change
// (RULE_15) Controller changes serviced command register to acknowledge
// (RULE_16) Acknowledging change zeroes status and error codes
// (RULE_17) Unit 2 uses its own digit and registers
// (RULE_18) Simultaneous changes: unit 1 first, then unit 2
// (RULE_19) Prescaled 10 ms tick, timer restarts after send
package spe_pkg;

  localparam int unsigned CLK_HZ   = 25_000_000;
  localparam int unsigned TICK_MS  = 10;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;

  localparam logic [7:0] ADR_CMD1  = 8'h0A;
  localparam logic [7:0] ADR_CMD2  = 8'h0B;
  localparam logic [7:0] ADR_STAT  = 8'h0C;
  localparam logic [7:0] ADR_ERR1  = 8'h0D;
  localparam logic [7:0] ADR_ERR2  = 8'h0E;
  localparam logic [7:0] ADR_TMO   = 8'h0F;
  localparam logic [7:0] ADR_PRESC = 8'h10;

  localparam logic [15:0] CMD_RST  = 16'h0000;
  localparam logic [15:0] TMO_RST  = 16'h0005;
  localparam logic [1:0]  MAX_TRY  = 2'h3;

  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_CR  = 8'h0D;
  localparam logic [7:0] CH_ONE = 8'h31;

  localparam logic [15:0] ST_ACK1 = 16'h0001;
  localparam logic [15:0] ST_NAK1 = 16'h0002;
  localparam logic [15:0] ST_NONE1 = 16'h0004;
  localparam logic [15:0] ST_ACK2 = 16'h0100;
  localparam logic [15:0] ST_NAK2 = 16'h0200;
  localparam logic [15:0] ST_NONE2 = 16'h0400;

  localparam logic [2:0] TX_LAST  = 3'h5;
  localparam logic [2:0] ACK_LAST = 3'h4;
  localparam logic [2:0] NAK_LAST = 3'h5;

  typedef enum logic [3:0] {
    spe_idle = 4'h1,
    spe_send = 4'h2,
    spe_wait = 4'h4,
    spe_done = 4'h8
  } spe_state_t;

  function automatic logic [7:0] hex_char(input logic [3:0] v);
    hex_char = (v < 4'hA) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
  endfunction

  // Valid flag in bit 4, digit value below
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      hex_val = {1'b1, 4'(c - 8'h30)};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      hex_val = {1'b1, 4'(c - 8'h37)};
    end else if (c >= 8'h61 && c <= 8'h66) begin
      hex_val = {1'b1, 4'(c - 8'h57)};
    end else begin
      hex_val = 5'h00;
    end
  endfunction

  function automatic logic [7:0] unit_char(input logic u);
    unit_char = CH_ONE + {7'h00, u};
  endfunction

  // Sum of up to four characters, carries above FF dropped
  function automatic logic [7:0] lrc4(input logic [7:0] a, input logic [7:0] b,
                                      input logic [7:0] c, input logic [7:0] e);
    lrc4 = 8'(a + b + c + e);
  endfunction

endpackage

/* File: common/spe_tick_if.sv */
// Link between the engine and its 10 ms tick prescaler
interface spe_tick_if;
  logic [23:0] period;
  logic        restart;
  logic        tick;
  modport ctl (output period, output restart, input tick);
  modport gen (input period, input restart, output tick);
endinterface

/* File: src/spe_tick.sv */
// Prescaler that makes the one-cycle 10 ms tick
module spe_tick (
  input wire logic clk,
  input wire logic resetn,
  spe_tick_if.gen  tk
);
  typedef struct packed {
    logic [23:0] cnt;
    logic        tick;
  } spe_tick_state_t;

  spe_tick_state_t q;
  spe_tick_state_t d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (tk.restart) begin
      d.cnt = 24'h000000; // see (RULE_19)
    end else if (q.cnt + 24'h000001 >= tk.period) begin
      d.cnt = 24'h000000;
      d.tick = 1'b1; // see (RULE_19)
    end else begin
      d.cnt = q.cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tk.tick = q.tick;
endmodule

/* File: src/spe_engine.sv */
// Command and reply engine serving two units on one serial byte stream
module spe_engine #(
  parameter logic [23:0] TICK_CYCLES = 24'(spe_pkg::TICK_CYC)
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid
);
  typedef struct packed {
    spe_pkg::spe_state_t st;
    logic [15:0] cmd1;
    logic [15:0] cmd2;
    logic        pend1;
    logic        pend2;
    logic [15:0] status;
    logic [15:0] err1;
    logic [15:0] err2;
    logic [15:0] tmo_set;
    logic [23:0] presc;
    logic        unit;
    logic [1:0]  tries;
    logic [2:0]  idx;
    logic [7:0]  txd;
    logic        txv;
    logic        restart;
    logic [15:0] tmo_cnt;
    logic [2:0]  ack_pos;
    logic [2:0]  nak_pos;
    logic [7:0]  nak_code;
    logic [31:0] rdat;
  } spe_eng_state_t;

  spe_eng_state_t q;
  spe_eng_state_t d;

  spe_tick_if tk ();

  spe_tick u_tick (
    .clk    (clk),
    .resetn (resetn),
    .tk     (tk.gen)
  );

  assign tk.period  = q.presc;
  assign tk.restart = q.restart;
  assign rdata      = q.rdat;
  assign tx_data    = q.txd;
  assign tx_valid   = q.txv;

  function automatic logic [7:0] frame_byte(input logic [2:0] i, input logic u,
                                            input logic [3:0] c);
    logic [7:0] uc;
    logic [7:0] cc;
    uc = spe_pkg::unit_char(u);
    cc = spe_pkg::hex_char(c);
    case (i)
      3'h0: frame_byte = spe_pkg::CH_STX;
      3'h1: frame_byte = uc;
      3'h2: frame_byte = cc;
      3'h3: frame_byte = spe_pkg::CH_ETX;
      3'h4: frame_byte = spe_pkg::lrc4(spe_pkg::CH_STX, uc, cc, spe_pkg::CH_ETX);
      default: frame_byte = spe_pkg::CH_CR;
    endcase
  endfunction

  // Matcher restart: a unit digit may open a new reply
  function automatic logic [2:0] resync(input logic [7:0] c, input logic [7:0] u);
    resync = (c == u) ? 3'h1 : 3'h0;
  endfunction

  logic [15:0] cur_cmd;
  logic [7:0]  uch;
  logic [7:0]  cch;
  logic [7:0]  ack_lrc;
  logic [7:0]  nak_lrc;
  logic [7:0]  ack_exp;
  logic        chg1;
  logic        chg2;
  logic        done_ack;
  logic        take1;
  logic        take2;
  logic        got_ack;
  logic        got_nak;
  logic        failed;
  logic        expired;
  logic [4:0]  hv;
  logic [4:0]  code_v;

  always_comb begin
    cur_cmd = q.unit ? q.cmd2 : q.cmd1; // see (RULE_17)
    uch     = spe_pkg::unit_char(q.unit);
    cch     = spe_pkg::hex_char(cur_cmd[3:0]);
    ack_lrc = spe_pkg::lrc4(uch, cch, spe_pkg::CH_ACK, 8'h00); // see (RULE_07)
    nak_lrc = spe_pkg::lrc4(uch, cch, q.nak_code, spe_pkg::CH_NAK); // see (RULE_08)
    case (q.ack_pos)
      3'h0: ack_exp = uch;
      3'h1: ack_exp = cch;
      3'h2: ack_exp = spe_pkg::CH_ACK;
      3'h3: ack_exp = ack_lrc;
      default: ack_exp = spe_pkg::CH_CR;
    endcase
    hv = spe_pkg::hex_val(rx_data);
    code_v = spe_pkg::hex_val(q.nak_code);
    // A write that alters the stored value is a change
    chg1 = wr && addr == spe_pkg::ADR_CMD1 && wdata[15:0] != q.cmd1; // see (RULE_01)
    chg2 = wr && addr == spe_pkg::ADR_CMD2 && wdata[15:0] != q.cmd2; // see (RULE_01)
    done_ack = q.st == spe_pkg::spe_done && (q.unit ? chg2 : chg1); // see (RULE_14)
    take1 = q.st == spe_pkg::spe_idle && q.pend1; // see (RULE_18)
    take2 = q.st == spe_pkg::spe_idle && !q.pend1 && q.pend2; // see (RULE_18)
  end

  always_comb begin
    d = q;
    d.restart = 1'b0;
    d.rdat    = 32'h00000000;
    got_ack   = 1'b0;
    got_nak   = 1'b0;
    failed    = 1'b0;
    expired   = 1'b0;

    // Register writes; status and error codes are read-only
    if (wr) begin
      case (addr)
        spe_pkg::ADR_CMD1:  d.cmd1 = wdata[15:0];
        spe_pkg::ADR_CMD2:  d.cmd2 = wdata[15:0];
        spe_pkg::ADR_TMO:   d.tmo_set = wdata[15:0];
        spe_pkg::ADR_PRESC: d.presc = wdata[23:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        spe_pkg::ADR_CMD1:  d.rdat = {16'h0000, q.cmd1};
        spe_pkg::ADR_CMD2:  d.rdat = {16'h0000, q.cmd2};
        spe_pkg::ADR_STAT:  d.rdat = {16'h0000, q.status};
        spe_pkg::ADR_ERR1:  d.rdat = {16'h0000, q.err1};
        spe_pkg::ADR_ERR2:  d.rdat = {16'h0000, q.err2};
        spe_pkg::ADR_TMO:   d.rdat = {16'h0000, q.tmo_set};
        spe_pkg::ADR_PRESC: d.rdat = {8'h00, q.presc};
        default:            d.rdat = 32'h00000000;
      endcase
    end

    // New change wins over the consuming clear; the acknowledging change is not queued
    d.pend1 = (q.pend1 & ~take1) | (chg1 & ~(done_ack & ~q.unit)); // see (RULE_18)
    d.pend2 = (q.pend2 & ~take2) | (chg2 & ~(done_ack & q.unit)); // see (RULE_14)

    case (q.st)
      spe_pkg::spe_idle: begin
        if (take1 || take2) begin
          d.unit  = take2; // see (RULE_17)
          d.tries = 2'h1;
          d.idx   = 3'h0;
          d.st    = spe_pkg::spe_send;
        end
      end
      spe_pkg::spe_send: begin
        if (!q.txv) begin
          d.txd = frame_byte(q.idx, q.unit, cur_cmd[3:0]); // see (RULE_02)
          d.txv = 1'b1;
        end else if (tx_ready) begin
          d.txv = 1'b0;
          if (q.idx == spe_pkg::TX_LAST) begin
            d.st      = spe_pkg::spe_wait;
            d.tmo_cnt = q.tmo_set; // see (RULE_09)
            d.restart = 1'b1; // see (RULE_19)
            d.ack_pos = 3'h0;
            d.nak_pos = 3'h0;
          end else begin
            d.idx = q.idx + 3'h1;
          end
        end
      end
      spe_pkg::spe_wait: begin
        if (tk.tick) begin
          if (q.tmo_cnt <= 16'h0001) begin
            expired = 1'b1; // see (RULE_03)
          end else begin
            d.tmo_cnt = q.tmo_cnt - 16'h0001;
          end
        end
        if (rx_valid) begin
          // Acknowledge matcher
          if (q.ack_pos == 3'h3 && rx_data != ack_lrc) begin
            failed = 1'b1; // see (RULE_05)
          end else if (rx_data == ack_exp) begin
            if (q.ack_pos == spe_pkg::ACK_LAST) begin
              got_ack = 1'b1; // see (RULE_06)
            end else begin
              d.ack_pos = q.ack_pos + 3'h1;
            end
          end else begin
            d.ack_pos = resync(rx_data, uch); // see (RULE_04)
          end
          // Error reply matcher
          case (q.nak_pos)
            3'h0: d.nak_pos = resync(rx_data, uch);
            3'h1: d.nak_pos = (rx_data == cch) ? 3'h2 : resync(rx_data, uch);
            3'h2: begin
              if (hv[4]) begin
                d.nak_code = rx_data; // see (RULE_08)
                d.nak_pos  = 3'h3;
              end else begin
                d.nak_pos = resync(rx_data, uch); // see (RULE_04)
              end
            end
            3'h3: d.nak_pos = (rx_data == spe_pkg::CH_NAK) ? 3'h4 : resync(rx_data, uch);
            3'h4: begin
              if (rx_data == nak_lrc) begin
                d.nak_pos = 3'h5;
              end else begin
                failed = 1'b1; // see (RULE_05)
              end
            end
            default: begin
              if (rx_data == spe_pkg::CH_CR) begin
                got_nak = 1'b1; // see (RULE_08)
              end else begin
                d.nak_pos = resync(rx_data, uch);
              end
            end
          endcase
        end
        if (got_ack) begin
          d.status = q.unit ? spe_pkg::ST_ACK2 : spe_pkg::ST_ACK1; // see (RULE_10)
          d.st     = spe_pkg::spe_done;
        end else if (got_nak) begin
          d.status = q.unit ? spe_pkg::ST_NAK2 : spe_pkg::ST_NAK1; // see (RULE_11)
          if (q.unit) begin
            d.err2 = {12'h000, code_v[3:0]}; // see (RULE_17)
          end else begin
            d.err1 = {12'h000, code_v[3:0]};
          end
          d.st = spe_pkg::spe_done;
        end else if (failed || expired) begin
          if (q.tries == spe_pkg::MAX_TRY) begin
            d.status = q.unit ? spe_pkg::ST_NONE2 : spe_pkg::ST_NONE1; // see (RULE_12)
            d.st     = spe_pkg::spe_done; // see (RULE_13)
          end else begin
            d.tries = q.tries + 2'h1; // see (RULE_05)
            d.idx   = 3'h0;
            d.st    = spe_pkg::spe_send;
          end
        end
      end
      spe_pkg::spe_done: begin
        if (done_ack) begin
          d.status = 16'h0000; // see (RULE_16)
          d.err1   = 16'h0000;
          d.err2   = 16'h0000;
          d.st     = spe_pkg::spe_idle;
        end
      end
      default: d.st = spe_pkg::spe_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q         <= '0;
      q.st      <= spe_pkg::spe_idle;
      q.cmd1    <= spe_pkg::CMD_RST;
      q.cmd2    <= spe_pkg::CMD_RST;
      q.tmo_set <= spe_pkg::TMO_RST;
      q.presc   <= TICK_CYCLES;
    end else begin
      q <= d;
    end
  end
endmodule

/* File: sim/spe_engine_sva.sv */
// Port checker for the serial unit poll engine
module spe_engine_sva (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] pos;
  logic [7:0] sum;

  // Byte position in the request and running sum
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pos <= 3'h0;
      sum <= 8'h00;
    end else if (tx_valid && tx_ready) begin
      pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
      sum <= (pos == 3'h0) ? tx_data : sum + tx_data;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_take;
    tx_valid && tx_ready;
  endsequence
  sequence s_gap_next;
    !tx_valid ##1 tx_valid;
  endsequence

  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("request byte dropped or changed before acceptance");
  a_byte_gap: assert property (s_take ##0 (pos != 3'h5) |=> s_gap_next)
    else $error("request bytes not sent with one idle cycle between");
  a_frame_marks: assert property (s_take |-> (pos != 3'h0 || tx_data == spe_pkg::CH_STX)
    && (pos != 3'h3 || tx_data == spe_pkg::CH_ETX) && (pos != 3'h5 || tx_data == spe_pkg::CH_CR))
    else $error("request framing byte wrong");
  a_unit_digit: assert property (s_take ##0 (pos == 3'h1) |-> tx_data inside {8'h31, 8'h32})
    else $error("unit digit wrong");
  a_cmd_char: assert property (s_take ##0 (pos == 3'h2)
    |-> tx_data inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("command character not a hex digit");
  a_frame_sum: assert property (s_take ##0 (pos == 3'h4) |-> tx_data == sum)
    else $error("request check byte wrong");
  a_wait_quiet: assert property (s_take ##0 (pos == 3'h5) |=> !tx_valid [*8])
    else $error("request sent again without waiting");
  a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data present without a read");
endmodule

bind spe_engine spe_engine_sva chk_u (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
  .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid);

/* File: sim/spe_unit_model.sv */
// Remote unit model: takes requests and answers in the chosen way
module spe_unit_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic [1:0] mode,
  input  wire logic [3:0] code,
  input  wire logic       slow,
  output logic      [7:0] frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rq[6];
  logic [7:0] q[$];
  int         pos;

  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction

  // Modes: 0 acknowledge, 1 error, 2 silent, 3 bad check byte
  task automatic reply();
    logic [7:0] s;
    q.push_back(8'h2A);
    q.push_back(rq[1]);
    q.push_back(rq[2]);
    if (mode == 2'h1) begin
      q.push_back(hx(code));
      q.push_back(8'h15);
      s = rq[1] + rq[2] + hx(code) + 8'h15;
    end else begin
      q.push_back(8'h06);
      s = rq[1] + rq[2] + 8'h06;
    end
    q.push_back((mode == 2'h3) ? s + 8'h01 : s);
    q.push_back(8'h0D);
  endtask

  always @(posedge clk) begin
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
    if (!resetn) begin
      pos = 0;
      frames <= 8'h00;
      rx_data <= 8'h55;
      tx_ready <= 1'b0;
      q.delete();
    end else if (tx_valid && tx_ready) begin
      rq[pos] = tx_data;
      pos = (pos == 5) ? 0 : pos + 1;
      if (pos == 0) begin
        frames <= frames + 8'h01;
        if (mode != 2'h2) begin
          reply();
        end
      end
    end else if (q.size() > 0 && !rx_valid) begin
      rx_data <= q.pop_front();
      rx_valid <= 1'b1;
    end
  end
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the serial unit poll engine
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, wr, rd, tx_valid, tx_ready, rx_valid, slow;
  logic [7:0]  addr, tx_data, rx_data, frames, f0;
  logic [31:0] wdata, rdata, s;
  logic [1:0]  mode;
  logic [3:0]  code;
  logic [15:0] cur[2];
  int          fail_count, total_checks;
  logic [7:0]  ra[8] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h20};
  logic [31:0] rv[8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h5, 32'hA, 32'h0};

  spe_engine #(.TICK_CYCLES(24'h00000A)) dut_u (.clk, .resetn, .addr, .wdata, .wr, .rd,
    .rdata, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid);
  spe_unit_model unit_u (.clk, .resetn, .tx_data, .tx_valid, .tx_ready, .rx_data,
    .rx_valid, .mode, .code, .slow, .frames);

  always #20 clk = ~clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_stat(output logic [31:0] v);
    v = 32'h0;
    for (int n = 0; n < 3000 && v === 32'h0; n++) begin
      rd_reg(8'h0C, v);
    end
    if (v === 32'h0) begin
      fail_count++;
      summarize();
    end
  endtask

  function automatic logic [31:0] exp_stat(input int u, input logic [1:0] m);
    logic [31:0] b;
    b = (m == 2'h0) ? 32'h1 : (m == 2'h1) ? 32'h2 : 32'h4;
    return (u != 0) ? b << 8 : b;
  endfunction

  task automatic trans(input int u, input logic [1:0] m);
    f0 = frames;
    mode <= m;
    code <= 4'($urandom);
    slow <= 1'($urandom);
    cur[u] = cur[u] + 16'(1 + $urandom_range(200));
    wr_reg(8'h0A + 8'(u), {16'h0, cur[u]});
    wait_stat(s);
    check(s, exp_stat(u, m));
    check(32'(frames - f0), (m < 2'h2) ? 32'h1 : 32'h3);
    rd_reg(8'h0D + 8'(u), s);
    check(s, (m == 2'h1) ? {28'h0, code} : 32'h0);
    cur[u] = cur[u] + 16'h1;
    wr_reg(8'h0A + 8'(u), {16'h0, cur[u]});
    rd_reg(8'h0C, s);
    check(s, 32'h0);
    rd_reg(8'h0D + 8'(u), s);
    check(s, 32'h0);
    repeat (40) @(posedge clk);
    check(32'(frames - f0), (m < 2'h2) ? 32'h1 : 32'h3);
  endtask

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    mode = 2'h0;
    code = 4'h0;
    slow = 1'b0;
    cur = '{16'h0, 16'h0};
    fail_count = 0;
    total_checks = 0;
    void'($urandom(99824));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_reg(ra[i], s);
      check(s, rv[i]);
    end
    wr_reg(8'h0C, 32'hFFFF);
    rd_reg(8'h0C, s);
    check(s, 32'h0);
    for (int k = 0; k < 10; k++) begin
      trans(k % 2, (k < 8) ? 2'(k / 2) : 2'($urandom_range(3)));
    end
    // Both units changed while busy, so both wait together
    mode <= 2'h0;
    cur[0] = cur[0] + 16'h1;
    cur[1] = cur[1] + 16'h1;
    wr_reg(8'h0A, {16'h0, cur[0]});
    wr_reg(8'h0B, {16'h0, cur[1]});
    cur[0] = cur[0] + 16'h1;
    wr_reg(8'h0A, {16'h0, cur[0]});
    wait_stat(s);
    check(s, 32'h1);
    cur[0] = cur[0] + 16'h1;
    wr_reg(8'h0A, {16'h0, cur[0]});
    wait_stat(s);
    check(s, 32'h1);
    cur[0] = cur[0] + 16'h1;
    wr_reg(8'h0A, {16'h0, cur[0]});
    wait_stat(s);
    check(s, 32'h100);
    cur[1] = cur[1] + 16'h1;
    wr_reg(8'h0B, {16'h0, cur[1]});
    // Same value again starts nothing
    f0 = frames;
    wr_reg(8'h0B, {16'h0, cur[1]});
    repeat (60) @(posedge clk);
    check(32'(frames - f0), 32'h0);
    summarize();
  end
endmodule
